// ==== core/bp_trace_pkg.sv ====
package bp_trace_pkg;

    // register selection on the coprocessor path (register 23)
    localparam logic [4:0] CP_REG_NUM        = 5'h17;
    localparam logic [2:0] SEL_TRIGGER_CTRL  = 3'h4;
    localparam logic [2:0] SEL_BREAK_INFO    = 3'h6;

    // trace_trigger_control field positions
    localparam int DATA_GATE_POS     = 31;
    localparam int DATA_ACTION_LO    = 16;
    localparam int DATA_ACTION_W     = 2;
    localparam int INSTR_GATE_POS    = 15;
    localparam int INSTR_ACTION_LO   = 0;
    localparam int INSTR_ACTION_W    = 6;
    localparam logic [31:0] TRIGGER_CTRL_RESET = 32'h0000_0000;

    // complex_break_info field positions
    localparam int PRIMED_POS        = 3;
    localparam int DATA_QUAL_POS     = 2;
    localparam int TUPLE_POS         = 1;
    localparam int PASS_COUNT_POS    = 0;
    localparam logic [3:0] BREAK_INFO_RESET = 4'h0;

    // coprocessor register access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [4:0] reg_num;
        logic [2:0] sel;
        logic [31:0] wdata;
    } cp_req_t;

    // complex-breakpoint features seen at debug exception entry
    typedef struct packed {
        logic primed;
        logic data_qual;
        logic tuple;
        logic pass_count;
    } cbrk_info_t;

    // trace on/off command to the trace generation logic
    typedef struct packed {
        logic start;
        logic stop;
    } trace_cmd_t;

    typedef enum logic [1:0] {
        TRC_OFF,
        TRC_ON
    } trace_state_t;

endpackage

// ==== core/bp_trigger_select.sv ====
`timescale 1ns/1ps
`default_nettype none

// resolves one class of breakpoint triggers into start/stop requests
module bp_trigger_select #(
    parameter int N = 6
) (
    // controls
    input  wire logic         gate_i,
    input  wire logic [N-1:0] action_i,
    input  wire logic [N-1:0] present_i,
    // triggers
    input  wire logic [N-1:0] trig_i,
    // requests
    output logic              start_o,
    output logic              stop_o
);
    wire logic [N-1:0] live_trig;

    if (N < 1) begin : g_bad_n
        $error("N must be at least 1");
    end

    // absent breakpoints never count, whatever their action bit
    assign live_trig = trig_i & present_i & {N{gate_i}};
    assign start_o   = |(live_trig & action_i);
    assign stop_o    = |(live_trig & ~action_i);
endmodule // bp_trigger_select

`default_nettype wire

// ==== core/cbrk_info_reg.sv ====
`timescale 1ns/1ps
`default_nettype none

// captures complex-breakpoint features at debug exception entry only
module cbrk_info_reg
    import bp_trace_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // capture
    input  wire logic       dbg_entry_i,
    input  wire cbrk_info_t feat_i,
    // state
    output cbrk_info_t      info_o
);
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            info_o <= cbrk_info_t'(BREAK_INFO_RESET);
        end else if (dbg_entry_i) begin
            info_o <= feat_i;
        end
    end
endmodule // cbrk_info_reg

`default_nettype wire

// ==== core/bp_trace_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module bp_trace_ctrl #(
    parameter int  NUM_IBP        = 6,
    parameter int  NUM_DBP        = 2,
    parameter bit  HAS_TRACE      = 1'b1,
    parameter bit  HAS_COMPLEX_BP = 1'b1
) (
    // clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    // coprocessor register path
    input  wire bp_trace_pkg::cp_req_t    cp_req_i,
    output logic [31:0]                   cp_rdata_o,
    output logic                          cp_hit_o,
    // breakpoint unit triggers
    input  wire logic [5:0]               ibp_trig_i,
    input  wire logic [1:0]               dbp_trig_i,
    // debug exception entry
    input  wire logic                     dbg_entry_i,
    input  wire bp_trace_pkg::cbrk_info_t cbrk_feat_i,
    // trace logic
    output bp_trace_pkg::trace_cmd_t      trace_cmd_o,
    output logic                          trace_on_o
);
    import bp_trace_pkg::*;

    // the register holds room for six and two breakpoints, no more
    if (NUM_IBP < 0 || NUM_IBP > INSTR_ACTION_W) begin : g_bad_ibp
        $error("NUM_IBP out of range");
    end
    if (NUM_DBP < 0 || NUM_DBP > DATA_ACTION_W) begin : g_bad_dbp
        $error("NUM_DBP out of range");
    end

    localparam bit CTRL_PRESENT = (NUM_IBP + NUM_DBP > 0) && HAS_TRACE;

    function automatic logic [5:0] present_mask(input int n);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (i < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    localparam logic [5:0] IBP_MASK = present_mask(NUM_IBP);
    localparam logic [5:0] DBP_MASK_FULL = present_mask(NUM_DBP);
    localparam logic [1:0] DBP_MASK = DBP_MASK_FULL[1:0];

    logic                      data_gate;
    logic [DATA_ACTION_W-1:0]  data_bp_action_bits;
    logic                      instr_gate;
    logic [INSTR_ACTION_W-1:0] instr_bp_action_bits;
    trace_state_t              trace_state;
    trace_state_t              next_trace_state;
    cbrk_info_t                break_info;
    logic [31:0]               read_mux;

    // register decode
    wire logic sel_ctrl = CTRL_PRESENT && cp_req_i.reg_num == CP_REG_NUM
                          && cp_req_i.sel == SEL_TRIGGER_CTRL;
    wire logic sel_info = HAS_COMPLEX_BP && cp_req_i.reg_num == CP_REG_NUM
                          && cp_req_i.sel == SEL_BREAK_INFO;
    wire logic wr_ctrl  = cp_req_i.wr && sel_ctrl;

    // only defined fields are stored; reserved ranges drop the write
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_gate            <= TRIGGER_CTRL_RESET[DATA_GATE_POS];
            data_bp_action_bits  <= TRIGGER_CTRL_RESET[DATA_ACTION_LO +: DATA_ACTION_W];
            instr_gate           <= TRIGGER_CTRL_RESET[INSTR_GATE_POS];
            instr_bp_action_bits <= TRIGGER_CTRL_RESET[INSTR_ACTION_LO +: INSTR_ACTION_W];
        end else if (wr_ctrl) begin
            data_gate            <= cp_req_i.wdata[DATA_GATE_POS];
            data_bp_action_bits  <= cp_req_i.wdata[DATA_ACTION_LO +: DATA_ACTION_W];
            instr_gate           <= cp_req_i.wdata[INSTR_GATE_POS];
            instr_bp_action_bits <= cp_req_i.wdata[INSTR_ACTION_LO +: INSTR_ACTION_W];
        end
    end

    // trigger resolution per class
    logic i_start;
    logic i_stop;
    logic d_start;
    logic d_stop;

    bp_trigger_select #(.N(INSTR_ACTION_W)) u_instr_sel (
        .gate_i    (instr_gate),
        .action_i  (instr_bp_action_bits),
        .present_i (IBP_MASK),
        .trig_i    (ibp_trig_i),
        .start_o   (i_start),
        .stop_o    (i_stop)
    );

    bp_trigger_select #(.N(DATA_ACTION_W)) u_data_sel (
        .gate_i    (data_gate),
        .action_i  (data_bp_action_bits),
        .present_i (DBP_MASK),
        .trig_i    (dbp_trig_i),
        .start_o   (d_start),
        .stop_o    (d_stop)
    );

    // triggers are only observed here; exception raising stays with the
    // breakpoint unit, so a breakpoint can do both
    wire logic any_start = CTRL_PRESENT && (i_start || d_start);
    wire logic any_stop  = CTRL_PRESENT && (i_stop || d_stop);

    // start wins over stop when two breakpoints disagree in one cycle
    always_comb begin
        next_trace_state = trace_state;
        unique case (trace_state)
            TRC_OFF: begin
                if (any_start) begin
                    next_trace_state = TRC_ON;
                end
            end
            TRC_ON: begin
                if (any_stop && !any_start) begin
                    next_trace_state = TRC_OFF;
                end
            end
            default: begin
                next_trace_state = TRC_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trace_state <= TRC_OFF;
            trace_cmd_o <= '0;
        end else begin
            trace_state       <= next_trace_state;
            trace_cmd_o.start <= any_start;
            trace_cmd_o.stop  <= any_stop && !any_start;
        end
    end

    assign trace_on_o = (trace_state == TRC_ON);

    // status register: no write path at all
    cbrk_info_reg u_info (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .dbg_entry_i (dbg_entry_i && HAS_COMPLEX_BP),
        .feat_i      (cbrk_feat_i),
        .info_o      (break_info)
    );

    wire logic [31:0] ctrl_word = {data_gate, 13'h0000, data_bp_action_bits,
                                   instr_gate, 9'h000, instr_bp_action_bits};
    wire logic [31:0] info_word = {28'h0000000, break_info.primed,
                                   break_info.data_qual,
                                   break_info.tuple,
                                   break_info.pass_count};

    assign read_mux = sel_ctrl ? ctrl_word : (sel_info ? info_word : 32'h0000_0000);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cp_rdata_o <= 32'h0000_0000;
        end else if (cp_req_i.rd) begin
            cp_rdata_o <= read_mux;
        end
    end

    assign cp_hit_o = sel_ctrl || sel_info;

endmodule // bp_trace_ctrl

`default_nettype wire

// ==== tb/bp_trace_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module bp_trace_props #(
    parameter int NUM_IBP = 6
) (
    input wire logic                     clk_sys_i,
    input wire logic                     sys_rst_i,
    input wire bp_trace_pkg::cp_req_t    cp_req_i,
    input wire logic [31:0]              cp_rdata_o,
    input wire logic                     cp_hit_o,
    input wire logic [5:0]               ibp_trig_i,
    input wire logic [1:0]               dbp_trig_i,
    input wire logic                     dbg_entry_i,
    input wire bp_trace_pkg::cbrk_info_t cbrk_feat_i,
    input wire bp_trace_pkg::trace_cmd_t trace_cmd_o,
    input wire logic                     trace_on_o
);
    import bp_trace_pkg::*;
    localparam logic [5:0] MSK = 6'((1 << NUM_IBP) - 1);
    logic [31:0] ctl;
    logic [3:0]  inf;
    wire       at_reg = cp_req_i.reg_num == CP_REG_NUM;
    wire       is_c   = at_reg && cp_req_i.sel == SEL_TRIGGER_CTRL;
    wire       is_s   = at_reg && cp_req_i.sel == SEL_BREAK_INFO;
    wire [5:0] ib     = ibp_trig_i & MSK & {6{ctl[15]}};
    wire [1:0] db     = dbp_trig_i & {2{ctl[31]}};
    wire       st_e   = |(ib & ctl[5:0]) || |(db & ctl[17:16]);
    wire       sp_e   = !st_e && (|(ib & ~ctl[5:0]) || |(db & ~ctl[17:16]));
    // shadow copy of the control register, reserved bits dropped
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctl <= '0;
            inf <= '0;
        end else begin
            if (cp_req_i.wr && is_c) ctl <= cp_req_i.wdata & 32'h8003_803f;
            if (dbg_entry_i) inf <= cbrk_feat_i;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    AST_START: assert property (st_e |=> trace_cmd_o.start)
        else $error("missing start");
    AST_NOSTART: assert property (!st_e |=> !trace_cmd_o.start)
        else $error("start without enabled trigger");
    AST_STOP: assert property (sp_e |=> trace_cmd_o.stop && !trace_cmd_o.start)
        else $error("missing stop");
    AST_ON: assert property (trace_cmd_o.start |-> trace_on_o)
        else $error("trace not running after start");
    AST_OFF: assert property (trace_cmd_o.stop |-> !trace_on_o)
        else $error("trace running after stop");
    AST_RDC: assert property (cp_req_i.rd && is_c |=> cp_rdata_o == $past(ctl))
        else $error("control read mismatch");
    AST_RDS: assert property (cp_req_i.rd && is_s |=> cp_rdata_o == 32'($past(inf)))
        else $error("status read mismatch");
    AST_HIT: assert property (cp_hit_o == (is_c || is_s))
        else $error("hit mismatch");
endmodule // bp_trace_props
bind bp_trace_ctrl bp_trace_props #(.NUM_IBP(NUM_IBP)) chk_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cp_req_i(cp_req_i),
    .cp_rdata_o(cp_rdata_o), .cp_hit_o(cp_hit_o), .ibp_trig_i(ibp_trig_i),
    .dbp_trig_i(dbp_trig_i), .dbg_entry_i(dbg_entry_i), .cbrk_feat_i(cbrk_feat_i),
    .trace_cmd_o(trace_cmd_o), .trace_on_o(trace_on_o));
`default_nettype wire

// ==== tb/bp_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bp_src_model (
    input  wire logic              clk_sys_i,
    output logic [5:0]             ibp_trig_o,
    output logic [1:0]             dbp_trig_o,
    output logic                   dbg_entry_o,
    output bp_trace_pkg::cbrk_info_t feat_o
);
    import bp_trace_pkg::*;
    initial begin
        ibp_trig_o = '0;
        dbp_trig_o = '0;
        dbg_entry_o = 1'b0;
        feat_o = '0;
    end
    // one-cycle pulses; features are not held once entry is gone
    task automatic fire(input logic [5:0] i, input logic [1:0] d,
                        input logic e, input cbrk_info_t f);
        @(posedge clk_sys_i);
        #1;
        ibp_trig_o = i;
        dbp_trig_o = d;
        dbg_entry_o = e;
        feat_o = f;
        @(posedge clk_sys_i);
        #1;
        ibp_trig_o = '0;
        dbp_trig_o = '0;
        dbg_entry_o = 1'b0;
        feat_o = ~f;
    endtask
endmodule // bp_src_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bp_trace_pkg::*;
    logic        clk_sys_i, sys_rst_i, hit, tr_on, on, te;
    cp_req_t     req;
    logic [31:0] rdata, ctl, seed;
    logic [5:0]  ib;
    logic [1:0]  db;
    logic        ent;
    cbrk_info_t  feat, tf, inf;
    trace_cmd_t  cmd, ec;
    int          err_total, comparisons, cyc;
    bp_trace_ctrl #(.NUM_IBP(2)) dut_u (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cp_req_i(req), .cp_rdata_o(rdata),
        .cp_hit_o(hit), .ibp_trig_i(ib), .dbp_trig_i(db), .dbg_entry_i(ent),
        .cbrk_feat_i(feat), .trace_cmd_o(cmd), .trace_on_o(tr_on));
    bp_src_model src_u (.clk_sys_i(clk_sys_i), .ibp_trig_o(ib), .dbp_trig_o(db),
        .dbg_entry_o(ent), .feat_o(feat));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [2:0] sel, input logic [31:0] d);
        @(posedge clk_sys_i);
        #1;
        req = '{rd: !w, wr: w, reg_num: CP_REG_NUM, sel: sel, wdata: d};
        @(posedge clk_sys_i);
        #1;
        chk(32'(hit), 32'(sel == SEL_TRIGGER_CTRL || sel == SEL_BREAK_INFO));
        req = '0;
    endtask
    task automatic rd(input logic [2:0] sel, input logic [31:0] exp);
        acc(1'b0, sel, 32'h0);
        chk(rdata, exp);
    endtask
    // only two instruction breakpoints are built into the bench's design
    function automatic trace_cmd_t exp_cmd(input logic [31:0] c, input logic [5:0] i,
                                           input logic [1:0] d);
        logic [5:0] m  = i & 6'h03 & {6{c[15]}};
        logic [1:0] n  = d & {2{c[31]}};
        logic       st = |(m & c[5:0]) || |(n & c[17:16]);
        logic       sp = |(m & ~c[5:0]) || |(n & ~c[17:16]);
        return '{start: st, stop: sp && !st};
    endfunction
    task automatic shot(input logic [5:0] i, input logic [1:0] d);
        te = 1'($random(seed));
        tf = cbrk_info_t'(4'($random(seed)));
        ec = exp_cmd(ctl, i, d);
        src_u.fire(i, d, te, tf);
        chk(32'(cmd), 32'(ec));
        if (ec.start) on = 1'b1;
        else if (ec.stop) on = 1'b0;
        chk(32'(tr_on), 32'(on));
        if (te) inf = tf;
        rd(SEL_BREAK_INFO, 32'(inf));
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 4000) begin
            err_total++;
            complete_run;
        end
    end
    initial begin
        seed = 32'h214d;
        req = '0;
        on = 1'b0;
        inf = '0;
        err_total = 0;
        comparisons = 0;
        cyc = 0;
        sys_rst_i = 1'b1;
        repeat (6) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
        rd(SEL_TRIGGER_CTRL, TRIGGER_CTRL_RESET);
        rd(3'h3, 32'h0);
        acc(1'b1, SEL_TRIGGER_CTRL, 32'hffff_ffff);
        rd(SEL_TRIGGER_CTRL, 32'h8003_803f);
        acc(1'b1, SEL_BREAK_INFO, 32'hf);
        rd(SEL_BREAK_INFO, 32'h0);
        ctl = 32'h8003_803f;
        shot(6'h3c, 2'h0);
        shot(6'h01, 2'h2);
        repeat (60) begin
            ctl = $random(seed);
            acc(1'b1, SEL_TRIGGER_CTRL, ctl);
            ctl = ctl & 32'h8003_803f;
            shot(6'($random(seed)), 2'($random(seed)));
        end
        // reset in mid-run must drop the trace state and both registers
        sys_rst_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk(32'(tr_on), 32'h0);
        chk(32'(cmd), 32'h0);
        sys_rst_i = 1'b0;
        on = 1'b0;
        inf = '0;
        rd(SEL_TRIGGER_CTRL, TRIGGER_CTRL_RESET);
        rd(SEL_BREAK_INFO, 32'h0);
        ctl = TRIGGER_CTRL_RESET;
        shot(6'h03, 2'h3);
        complete_run;
    end
endmodule // tb
`default_nettype wire
